// ===== rtl/sfs_defs.svh
// offsets, widths, header codes and reset values of the slot field splitter
`ifndef SFS_DEFS_SVH
`define SFS_DEFS_SVH
`define SFS_FRAME_BITS   388
`define SFS_A_BITS       64
`define SFS_HDR_BITS     8
`define SFS_TAIL_BITS    40
`define SFS_ACRC_POS     48
`define SFS_ACRC_BITS    16
`define SFS_B_BITS       324
`define SFS_BDATA_BITS   320
`define SFS_X_POS        384
`define SFS_X_BITS       4
`define SFS_REDUND_BITS  64
`define SFS_SUB_NUM      4
`define SFS_SUB_DATA     64
`define SFS_SUB_CHK      16
`define SFS_SUB_SPAN     80
`define SFS_SINGLE_DATA  304
`define SFS_HDR_TAIL_MSB 6
`define SFS_HDR_TAIL_LSB 4
`define SFS_HDR_BMUX_MSB 3
`define SFS_HDR_BMUX_LSB 1
`define SFS_TAIL_PAGING  3'h0
`define SFS_TAIL_IDENT   3'h1
`define SFS_TAIL_SYSINFO 3'h2
`define SFS_TAIL_CONTROL 3'h3
`define SFS_TAIL_CIPHER  3'h4
`define SFS_BMUX_USER    3'h0
`define SFS_BMUX_CTRL    3'h1
`define SFS_BMUX_MIXED   3'h2
`define SFS_A_CRC_POLY   16'h1021
`define SFS_RB_CRC_POLY  16'h8005
`define SFS_X_CRC_POLY   4'h3
`define SFS_A_CRC_INIT   16'h0000
`define SFS_RB_CRC_INIT  16'h0000
`define SFS_X_CRC_INIT   4'h0
`define SFS_BUF_DEPTH    2
`endif

// ===== rtl/sfs_pkg.sv
// types shared by the slot field splitter modules
`include "sfs_defs.svh"
package sfs_pkg;
  typedef enum logic [2:0] {
    TK_PAGING, TK_IDENT, TK_SYSINFO, TK_CONTROL, TK_CIPHER, TK_UNKNOWN
  } sfs_tail_kind_t;
  typedef enum logic [1:0] {
    LY_UNPROT, LY_MULTI, LY_SINGLE
  } sfs_layout_t;
  typedef enum logic [1:0] {
    ST_IDLE, ST_RECV, ST_HOLD
  } sfs_state_t;
  typedef struct packed {
    logic [`SFS_HDR_BITS-1:0]                       header;
    logic [`SFS_TAIL_BITS-1:0]                      tail;
    sfs_tail_kind_t                                 tail_kind;
    sfs_layout_t                                    layout;
    logic                                           cipher_ctrl;
    logic [`SFS_BDATA_BITS-1:0]                     data;
    logic [`SFS_ACRC_BITS-1:0]                      a_crc;
    logic                                           a_ok;
    logic [`SFS_SUB_NUM-1:0][`SFS_SUB_CHK-1:0]      rb_calc;
    logic [`SFS_SUB_NUM-1:0]                        rb_ok;
    logic [`SFS_X_BITS-1:0]                         x_calc;
    logic                                           x_ok;
  } sfs_word_t;
endpackage : sfs_pkg

// ===== rtl/sfs_if.sv
// valid/ready carrier for split frame words between the framer and its buffer
`timescale 1ns/1ps
interface sfs_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sfs_if

// ===== rtl/sfs_buf.sv
// small fifo holding split frame words until the upper logic takes them
`timescale 1ns/1ps
`include "sfs_defs.svh"
module sfs_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SFS_BUF_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  sfs_if.snk                    in_if,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff, nxt_wr_ptr;
  logic [AW-1:0]    rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push;
  logic             pop;

  // back-pressure: a full buffer drops ready so the framer holds its word
  assign in_if.ready = i_ce && (cnt_ff != FULL_CNT);
  assign o_valid     = (cnt_ff != '0);
  assign o_data      = mem_ff[rd_ptr_ff];
  assign push        = in_if.valid && in_if.ready;
  assign pop         = i_ce && o_valid && i_ready;

  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_cnt    = cnt_ff;
    if (push) begin
      nxt_wr_ptr = (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd_ptr = (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else if (i_ce) begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff    <= nxt_cnt;
    end
  end

  // storage needs no reset; valid entries are tracked by the count
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_if.data;
    end
  end
endmodule : sfs_buf

// ===== rtl/slot_field_splitter.sv
// full-slot physical field splitter: bit stream in, split and checked fields out
`timescale 1ns/1ps
`include "sfs_defs.svh"
module slot_field_splitter
  import sfs_pkg::*;
#(
  parameter logic [`SFS_ACRC_BITS-1:0] A_POLY  = `SFS_A_CRC_POLY,
  parameter logic [`SFS_SUB_CHK-1:0]   RB_POLY = `SFS_RB_CRC_POLY,
  parameter logic [`SFS_X_BITS-1:0]    X_POLY  = `SFS_X_CRC_POLY,
  parameter int                        DEPTH   = `SFS_BUF_DEPTH
) (
  input  wire logic                                  I_SYS_CLK,
  input  wire logic                                  I_RESET,
  input  wire logic                                  I_CE,
  input  wire logic                                  I_RX_BIT,
  input  wire logic                                  I_RX_VALID,
  input  wire logic                                  I_RX_SOF,
  output logic                                       O_RX_READY,
  input  wire logic                                  I_SVC_PROTECTED,
  input  wire logic                                  I_SVC_SINGLE,
  output logic                                       O_VALID,
  input  wire logic                                  I_READY,
  output logic [`SFS_HDR_BITS-1:0]                   O_HEADER,
  output logic [`SFS_TAIL_BITS-1:0]                  O_TAIL,
  output logic [2:0]                                 O_TAIL_KIND,
  output logic [1:0]                                 O_LAYOUT,
  output logic                                       O_CIPHER_CTRL,
  output logic [`SFS_BDATA_BITS-1:0]                 O_DATA,
  output logic [`SFS_ACRC_BITS-1:0]                  O_A_CRC,
  output logic                                       O_A_OK,
  output logic [`SFS_SUB_NUM*`SFS_SUB_CHK-1:0]       O_RB_CALC,
  output logic [`SFS_SUB_NUM-1:0]                    O_RB_OK,
  output logic [`SFS_X_BITS-1:0]                     O_X_CALC,
  output logic                                       O_X_OK
);
  localparam int        FB   = `SFS_FRAME_BITS;
  localparam int        WW   = $bits(sfs_word_t);
  localparam logic [8:0] LAST = 9'(FB - 1);

  sfs_state_t                               state_ff, nxt_state;
  logic [FB-1:0]                            frame_ff, nxt_frame;
  logic [8:0]                               cnt_ff, nxt_cnt;
  logic [`SFS_ACRC_BITS-1:0]                a_crc_ff, nxt_a_crc;
  logic [`SFS_X_BITS-1:0]                   x_crc_ff, nxt_x_crc;
  logic [`SFS_SUB_CHK-1:0]                  sub_crc_ff, nxt_sub_crc;
  logic [`SFS_SUB_NUM-1:0][`SFS_SUB_CHK-1:0] rb_ff, nxt_rb;
  logic [1:0]                               sub_idx_ff, nxt_sub_idx;
  logic [6:0]                               sub_off_ff, nxt_sub_off;
  sfs_layout_t                              layout_ff, nxt_layout;
  logic                                     cipher_ctrl_ff, nxt_cipher_ctrl;
  logic [`SFS_SUB_NUM-1:0]                  rb_ok;
  sfs_word_t                                word;
  sfs_word_t                                out_word;

  sfs_if #(.WIDTH(WW)) word_if ();

  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic b,
                                             input logic [15:0] poly);
    crc16_step = {c[14:0], 1'b0} ^ (poly & {16{c[15] ^ b}});
  endfunction : crc16_step

  function automatic logic [3:0] crc4_step(input logic [3:0] c, input logic b);
    crc4_step = {c[2:0], 1'b0} ^ (X_POLY & {4{c[3] ^ b}});
  endfunction : crc4_step

  assign O_RX_READY = I_CE && (state_ff != ST_HOLD);

  always_comb begin
    logic       take;
    logic [8:0] pos;
    logic [8:0] bp;
    logic [7:0] hdr;
    take            = 1'b0;
    pos             = cnt_ff;
    bp              = '0;
    hdr             = frame_ff[`SFS_HDR_BITS-1:0];
    nxt_state       = state_ff;
    nxt_frame       = frame_ff;
    nxt_cnt         = cnt_ff;
    nxt_a_crc       = a_crc_ff;
    nxt_x_crc       = x_crc_ff;
    nxt_sub_crc     = sub_crc_ff;
    nxt_rb          = rb_ff;
    nxt_sub_idx     = sub_idx_ff;
    nxt_sub_off     = sub_off_ff;
    nxt_layout      = layout_ff;
    nxt_cipher_ctrl = cipher_ctrl_ff;
    // a start marker restarts framing even in mid-frame; a held word blocks it
    take = I_RX_VALID && O_RX_READY && ((state_ff == ST_RECV) || I_RX_SOF);
    if (take) begin
      if (I_RX_SOF) begin
        pos         = '0;
        nxt_a_crc   = `SFS_A_CRC_INIT;
        nxt_x_crc   = `SFS_X_CRC_INIT;
        nxt_sub_crc = `SFS_RB_CRC_INIT;
        nxt_rb      = '0;
      end
      nxt_frame = {frame_ff[FB-2:0], I_RX_BIT};
      nxt_cnt   = pos + 9'h001;
      nxt_state = ST_RECV;
      if (pos < 9'(`SFS_ACRC_POS)) begin
        nxt_a_crc = crc16_step(nxt_a_crc, I_RX_BIT, A_POLY);
      end
      if (pos == 9'(`SFS_HDR_BITS)) begin
        // header complete: B kind and service type fix the layout
        nxt_cipher_ctrl = 1'b0;
        nxt_sub_idx     = '0;
        nxt_sub_off     = '0;
        case (hdr[`SFS_HDR_BMUX_MSB:`SFS_HDR_BMUX_LSB])
          `SFS_BMUX_USER: begin
            if (!I_SVC_PROTECTED) begin
              nxt_layout = LY_UNPROT;
            end else if (I_SVC_SINGLE) begin
              nxt_layout = LY_SINGLE;
            end else begin
              nxt_layout = LY_MULTI;
            end
          end
          `SFS_BMUX_CTRL: begin
            nxt_layout      = LY_MULTI;
            nxt_cipher_ctrl = 1'b1;
          end
          default: begin
            // mixed and unknown codes take the safer protected handling
            nxt_layout      = LY_MULTI;
            nxt_cipher_ctrl = 1'b1;
          end
        endcase
      end
      if (pos >= 9'(`SFS_A_BITS) && pos < 9'(`SFS_X_POS)) begin
        bp        = pos - 9'(`SFS_A_BITS);
        nxt_x_crc = crc4_step(nxt_x_crc, I_RX_BIT);
        if (layout_ff == LY_MULTI) begin
          if (sub_off_ff < 7'(`SFS_SUB_DATA)) begin
            nxt_sub_crc = crc16_step(nxt_sub_crc, I_RX_BIT, RB_POLY);
          end
          if (sub_off_ff == 7'(`SFS_SUB_DATA - 1)) begin
            nxt_rb[sub_idx_ff] = nxt_sub_crc;
            nxt_sub_crc        = `SFS_RB_CRC_INIT;
          end
          if (sub_off_ff == 7'(`SFS_SUB_SPAN - 1)) begin
            nxt_sub_off = '0;
            nxt_sub_idx = sub_idx_ff + 2'h1;
          end else begin
            nxt_sub_off = sub_off_ff + 7'h01;
          end
        end else if (layout_ff == LY_SINGLE && bp < 9'(`SFS_SINGLE_DATA)) begin
          nxt_sub_crc = crc16_step(nxt_sub_crc, I_RX_BIT, RB_POLY);
          if (bp == 9'(`SFS_SINGLE_DATA - 1)) begin
            nxt_rb[0] = nxt_sub_crc;
          end
        end
      end
      if (pos == LAST) begin
        nxt_state = ST_HOLD;
      end
    end else if (state_ff == ST_HOLD && word_if.ready) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      state_ff       <= ST_IDLE;
      frame_ff       <= '0;
      cnt_ff         <= '0;
      a_crc_ff       <= `SFS_A_CRC_INIT;
      x_crc_ff       <= `SFS_X_CRC_INIT;
      sub_crc_ff     <= `SFS_RB_CRC_INIT;
      rb_ff          <= '0;
      sub_idx_ff     <= '0;
      sub_off_ff     <= '0;
      layout_ff      <= LY_UNPROT;
      cipher_ctrl_ff <= 1'b0;
    end else if (I_CE) begin
      state_ff       <= nxt_state;
      frame_ff       <= nxt_frame;
      cnt_ff         <= nxt_cnt;
      a_crc_ff       <= nxt_a_crc;
      x_crc_ff       <= nxt_x_crc;
      sub_crc_ff     <= nxt_sub_crc;
      rb_ff          <= nxt_rb;
      sub_idx_ff     <= nxt_sub_idx;
      sub_off_ff     <= nxt_sub_off;
      layout_ff      <= nxt_layout;
      cipher_ctrl_ff <= nxt_cipher_ctrl;
    end
  end

  // received subfield checks; unused subfields report ok so a mask is not needed
  for (genvar j = 0; j < `SFS_SUB_NUM; j++) begin : g_rb
    localparam int MPOS = `SFS_A_BITS + j * `SFS_SUB_SPAN + `SFS_SUB_DATA;
    localparam int SPOS = `SFS_A_BITS + `SFS_SINGLE_DATA;
    always_comb begin
      if (layout_ff == LY_MULTI) begin
        rb_ok[j] = (rb_ff[j] == frame_ff[FB-1-MPOS -: `SFS_SUB_CHK]);
      end else if (layout_ff == LY_SINGLE && j == 0) begin
        rb_ok[j] = (rb_ff[j] == frame_ff[FB-1-SPOS -: `SFS_SUB_CHK]);
      end else begin
        rb_ok[j] = 1'b1;
      end
    end
  end

  always_comb begin
    logic [2:0] tcode;
    tcode            = frame_ff[FB-1-(`SFS_HDR_BITS-1-`SFS_HDR_TAIL_MSB) -: 3];
    word             = '0;
    word.header      = frame_ff[FB-1 -: `SFS_HDR_BITS];
    word.tail        = frame_ff[FB-1-`SFS_HDR_BITS -: `SFS_TAIL_BITS];
    word.layout      = layout_ff;
    word.cipher_ctrl = cipher_ctrl_ff;
    word.data        = frame_ff[FB-1-`SFS_A_BITS -: `SFS_BDATA_BITS];
    word.a_crc       = a_crc_ff;
    word.a_ok        = (a_crc_ff == frame_ff[FB-1-`SFS_ACRC_POS -: `SFS_ACRC_BITS]);
    word.rb_calc     = rb_ff;
    word.rb_ok       = rb_ok;
    word.x_calc      = x_crc_ff;
    word.x_ok        = (x_crc_ff == frame_ff[`SFS_X_BITS-1:0]);
    case (tcode)
      `SFS_TAIL_PAGING:  word.tail_kind = TK_PAGING;
      `SFS_TAIL_IDENT:   word.tail_kind = TK_IDENT;
      `SFS_TAIL_SYSINFO: word.tail_kind = TK_SYSINFO;
      `SFS_TAIL_CONTROL: word.tail_kind = TK_CONTROL;
      `SFS_TAIL_CIPHER:  word.tail_kind = TK_CIPHER;
      default:           word.tail_kind = TK_UNKNOWN;
    endcase
  end

  assign word_if.valid = (state_ff == ST_HOLD);
  assign word_if.data  = word;

  // two words of slack so a receiver stall does not drop a finished frame
  sfs_buf #(.WIDTH(WW), .DEPTH(DEPTH)) u_buf (
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_RESET),
    .i_ce    (I_CE),
    .in_if   (word_if),
    .o_valid (O_VALID),
    .i_ready (I_READY),
    .o_data  (out_word)
  );

  assign O_HEADER      = out_word.header;
  assign O_TAIL        = out_word.tail;
  assign O_TAIL_KIND   = out_word.tail_kind;
  assign O_LAYOUT      = out_word.layout;
  assign O_CIPHER_CTRL = out_word.cipher_ctrl;
  assign O_DATA        = out_word.data;
  assign O_A_CRC       = out_word.a_crc;
  assign O_A_OK        = out_word.a_ok;
  assign O_RB_CALC     = out_word.rb_calc;
  assign O_RB_OK       = out_word.rb_ok;
  assign O_X_CALC      = out_word.x_calc;
  assign O_X_OK        = out_word.x_ok;
endmodule : slot_field_splitter

// ===== tb/sfs_properties.sv
// port-level property checker for the slot field splitter
`timescale 1ns/1ps
module sfs_properties (
  input wire logic         I_SYS_CLK,
  input wire logic         I_RESET,
  input wire logic         I_CE,
  input wire logic         I_READY,
  input wire logic         O_RX_READY,
  input wire logic         O_VALID,
  input wire logic [7:0]   O_HEADER,
  input wire logic [2:0]   O_TAIL_KIND,
  input wire logic [1:0]   O_LAYOUT,
  input wire logic         O_CIPHER_CTRL,
  input wire logic [319:0] O_DATA,
  input wire logic [63:0]  O_RB_CALC,
  input wire logic [3:0]   O_RB_OK
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);
  ready_gate_a: assert property (!I_CE |-> !O_RX_READY)
    else $error("frame input ready while clock enable low");
  reset_empty_a: assert property (disable iff (1'b0) I_RESET |=> !O_VALID)
    else $error("word shown right after reset");
  // an empty buffer must absorb a finished frame in one cycle
  hold_short_a: assert property ($fell(O_RX_READY) && I_CE && !O_VALID |=> O_RX_READY && O_VALID)
    else $error("finished frame not pushed at once");
  word_stable_a: assert property (O_VALID && !(I_READY && I_CE) |=> O_VALID && $stable(O_DATA))
    else $error("word changed before taken");
  tail_kind_a: assert property (O_VALID |-> O_TAIL_KIND == ((O_HEADER[6:4] > 3'h4) ? 3'h5 : O_HEADER[6:4]))
    else $error("tail kind does not follow header code");
  cipher_kind_a: assert property (O_VALID |-> O_CIPHER_CTRL == (O_HEADER[3:1] != 3'h0))
    else $error("cipher kind does not follow header code");
  ctrl_layout_a: assert property (O_VALID && O_HEADER[3:1] != 3'h0 |-> O_LAYOUT == 2'h1)
    else $error("control kind not in multisubfield layout");
  unprot_checks_a: assert property (O_VALID && O_LAYOUT == 2'h0 |-> O_RB_OK == 4'hf && O_RB_CALC == '0)
    else $error("unprotected word carries subfield checks");
  multi_checks_a: assert property (O_VALID && O_LAYOUT == 2'h1 |-> O_RB_OK ==
    {O_RB_CALC[63:48] == O_DATA[15:0], O_RB_CALC[47:32] == O_DATA[95:80],
     O_RB_CALC[31:16] == O_DATA[175:160], O_RB_CALC[15:0] == O_DATA[255:240]})
    else $error("subfield check flags wrong");
  single_check_a: assert property (O_VALID && O_LAYOUT == 2'h2 |->
    O_RB_OK == {3'h7, O_RB_CALC[15:0] == O_DATA[15:0]})
    else $error("single subfield check flag wrong");
  cover property (O_VALID && !O_RX_READY && I_CE);
  cover property (O_VALID && O_LAYOUT == 2'h2);
  cover property (O_VALID && O_LAYOUT == 2'h1 && O_RB_OK != 4'hf);
endmodule : sfs_properties

bind slot_field_splitter sfs_properties u_props (.I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET),
  .I_CE(I_CE), .I_READY(I_READY), .O_RX_READY(O_RX_READY), .O_VALID(O_VALID),
  .O_HEADER(O_HEADER), .O_TAIL_KIND(O_TAIL_KIND), .O_LAYOUT(O_LAYOUT),
  .O_CIPHER_CTRL(O_CIPHER_CTRL), .O_DATA(O_DATA), .O_RB_CALC(O_RB_CALC), .O_RB_OK(O_RB_OK));

// ===== tb/sfs_far_end.sv
// physical channel bit source feeding the splitter
`timescale 1ns/1ps
module sfs_far_end (
  input  wire logic i_clk,
  input  wire logic i_rx_ready,
  output logic      o_bit,
  output logic      o_bit_valid,
  output logic      o_sof
);
  int hang;
  initial begin
    o_bit = 1'b0;
    o_bit_valid = 1'b0;
    o_sof = 1'b0;
    hang = 0;
  end
  // bit held until taken; gap > 0 gives a slow source, line toggles when not valid
  task automatic send(input logic [387:0] f, input int n, input int gap, input bit sof);
    int k;
    int w;
    logic r;
    k = 0;
    w = 0;
    @(posedge i_clk);
    while (k < n && hang == 0) begin
      #1;
      o_bit = f[387-k];
      o_bit_valid = 1'b1;
      o_sof = sof && (k == 0);
      @(negedge i_clk);
      r = i_rx_ready;
      @(posedge i_clk);
      if (r) begin
        k++;
        w = 0;
        for (int g = 0; g < gap; g++) begin
          #1;
          o_bit_valid = 1'b0;
          o_sof = 1'b0;
          o_bit = ~o_bit;
          @(posedge i_clk);
        end
      end else if (++w > 400) hang = 1;
    end
    #1;
    o_bit_valid = 1'b0;
    o_sof = 1'b0;
    o_bit = ~o_bit;
  endtask : send
endmodule : sfs_far_end

// ===== tb/tb.sv
// self-checking bench for the slot field splitter
`timescale 1ns/1ps
`include "sfs_defs.svh"
module tb;
  typedef struct {logic [7:0] hdr; logic prot; logic single; logic [2:0] kind;
    logic [1:0] lay; logic ciph; logic [1:0] bad;} sfs_row_t;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         ce = 1'b1;
  logic         rdy = 1'b0;
  logic         prot = 1'b0;
  logic         single = 1'b0;
  logic         rx_bit, rx_val, sof, rx_rdy, o_valid, o_cipher, o_a_ok, o_x_ok;
  logic [7:0]   o_header;
  logic [39:0]  o_tail;
  logic [2:0]   o_kind;
  logic [1:0]   o_layout;
  logic [319:0] o_data;
  logic [15:0]  o_a_crc;
  logic [63:0]  o_rb_calc;
  logic [3:0]   o_rb_ok, o_x_calc;
  logic [387:0] f;
  logic [387:0] q [3];
  int           error_cnt = 0;
  int           comparisons = 0;
  sfs_row_t     rows [7] = '{'{8'h00, 0, 0, 3'h0, 2'h0, 0, 2'h0},
    '{8'h12, 0, 0, 3'h1, 2'h1, 1, 2'h1}, '{8'h24, 0, 0, 3'h2, 2'h1, 1, 2'h2},
    '{8'h30, 1, 0, 3'h3, 2'h1, 0, 2'h1}, '{8'h40, 1, 1, 3'h4, 2'h2, 0, 2'h1},
    '{8'hf6, 1, 1, 3'h5, 2'h1, 1, 2'h3}, '{8'h50, 0, 1, 3'h5, 2'h0, 0, 2'h0}};

  always #2.5 clk = ~clk;

  sfs_far_end far (.i_clk(clk), .i_rx_ready(rx_rdy), .o_bit(rx_bit), .o_bit_valid(rx_val),
    .o_sof(sof));
  slot_field_splitter #(.A_POLY(`SFS_A_CRC_POLY), .RB_POLY(`SFS_RB_CRC_POLY),
    .X_POLY(`SFS_X_CRC_POLY), .DEPTH(2)) dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_CE(ce),
    .I_RX_BIT(rx_bit), .I_RX_VALID(rx_val), .I_RX_SOF(sof), .O_RX_READY(rx_rdy),
    .I_SVC_PROTECTED(prot), .I_SVC_SINGLE(single), .O_VALID(o_valid), .I_READY(rdy),
    .O_HEADER(o_header), .O_TAIL(o_tail), .O_TAIL_KIND(o_kind), .O_LAYOUT(o_layout),
    .O_CIPHER_CTRL(o_cipher), .O_DATA(o_data), .O_A_CRC(o_a_crc), .O_A_OK(o_a_ok),
    .O_RB_CALC(o_rb_calc), .O_RB_OK(o_rb_ok), .O_X_CALC(o_x_calc), .O_X_OK(o_x_ok));

  task automatic finish_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [319:0] e, input logic [319:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // msb-first shift, zero start, no final inversion; pos k of the frame is f[387-k]
  function automatic logic [15:0] crc(input logic [387:0] v, input int lo, input int n,
                                      input int w, input logic [15:0] poly);
    logic [15:0] c;
    logic        fb;
    c = '0;
    for (int i = 0; i < n; i++) begin
      fb = c[w-1] ^ v[387-lo-i];
      c = c << 1;
      if (fb) c = c ^ poly;
      c = c & 16'((1 << w) - 1);
    end
    return c;
  endfunction : crc

  function automatic logic [387:0] mk(input logic [7:0] h, input logic [1:0] lay,
                                      input int s, input logic [1:0] bad);
    logic [387:0] v;
    v = {h, 380'({12{32'h9e3779b1 * s ^ 32'h0f1e2d3c}})};
    v[339:324] = crc(v, 0, 48, 16, `SFS_A_CRC_POLY);
    for (int j = 0; j < 4; j++)
      if (lay == 2'h1) v[259-80*j -: 16] = crc(v, 64+80*j, 64, 16, `SFS_RB_CRC_POLY);
    if (lay == 2'h2) v[19:4] = crc(v, 64, 304, 16, `SFS_RB_CRC_POLY);
    v[3:0] = 4'(crc(v, 64, 320, 4, 16'(`SFS_X_CRC_POLY)));
    if (bad[0]) v[300] = ~v[300];
    if (bad[1]) v[330] = ~v[330];
    return v;
  endfunction : mk

  task automatic expect_word(input logic [387:0] v, input sfs_row_t r);
    logic [63:0] calc;
    logic [3:0]  ok;
    logic [15:0] xc;
    logic [15:0] ac;
    calc = '0;
    ok = 4'hf;
    for (int j = 0; j < 4; j++)
      if (r.lay == 2'h1) begin
        calc[16*j +: 16] = crc(v, 64+80*j, 64, 16, `SFS_RB_CRC_POLY);
        ok[j] = calc[16*j +: 16] == v[259-80*j -: 16];
      end
    if (r.lay == 2'h2) begin
      calc[15:0] = crc(v, 64, 304, 16, `SFS_RB_CRC_POLY);
      ok[0] = calc[15:0] == v[19:4];
    end
    xc = crc(v, 64, 320, 4, 16'(`SFS_X_CRC_POLY));
    ac = crc(v, 0, 48, 16, `SFS_A_CRC_POLY);
    chk("header", v[387:380], o_header);
    chk("tail", v[379:340], o_tail);
    chk("a_crc", ac, o_a_crc);
    chk("a_ok", ac == v[339:324], o_a_ok);
    chk("tail_kind", r.kind, o_kind);
    chk("data", v[323:4], o_data);
    chk("x_calc", xc[3:0], o_x_calc);
    chk("x_ok", xc[3:0] == v[3:0], o_x_ok);
    chk("layout", r.lay, o_layout);
    chk("cipher", r.ciph, o_cipher);
    if (r.lay == 2'h2) chk("rb_calc", calc[15:0], o_rb_calc[15:0]);
    else chk("rb_calc", calc, o_rb_calc);
    chk("rb_ok", ok, o_rb_ok);
  endtask : expect_word

  task automatic xfer(input logic [387:0] v, input int n, input int gap, input bit s,
                      input sfs_row_t r);
    prot = r.prot;
    single = r.single;
    far.send(v, n, gap, s);
    if (far.hang != 0) begin
      chk("source_stuck", 0, far.hang);
      finish_test();
    end
  endtask : xfer

  task automatic wait_valid;
    int n;
    n = 0;
    while (o_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("valid", 1'b1, o_valid);
    if (o_valid !== 1'b1) finish_test();
  endtask : wait_valid

  task automatic pop;
    @(posedge clk);
    #1 rdy = 1'b1;
    @(posedge clk);
    #1 rdy = 1'b0;
  endtask : pop

  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    chk("valid_rst", 1'b0, o_valid);
    for (int i = 0; i < 7; i++) begin
      f = mk(rows[i].hdr, rows[i].lay, i + 1, rows[i].bad);
      xfer(f, 388, i % 2, 1'b1, rows[i]);
      wait_valid();
      expect_word(f, rows[i]);
      pop();
    end
    // receiver stalled: two words buffered, third frame held and input refused
    for (int i = 0; i < 3; i++) begin
      q[i] = mk(rows[1].hdr, 2'h1, 20 + i, 2'h0);
      xfer(q[i], 388, 0, 1'b1, rows[1]);
    end
    repeat (4) @(negedge clk);
    chk("rx_ready_full", 1'b0, rx_rdy);
    for (int i = 0; i < 3; i++) begin
      wait_valid();
      expect_word(q[i], rows[1]);
      pop();
    end
    @(negedge clk);
    chk("valid_empty", 1'b0, o_valid);
    // stray bits while idle, then a cut frame restarted by a new start
    xfer(f, 50, 0, 1'b0, rows[0]);
    xfer(f, 100, 0, 1'b1, rows[0]);
    f = mk(8'h00, 2'h0, 41, 2'h0);
    xfer(f, 388, 0, 1'b1, rows[0]);
    wait_valid();
    expect_word(f, rows[0]);
    @(posedge clk);
    #1 ce = 1'b0;
    rdy = 1'b1;
    repeat (3) @(negedge clk);
    chk("rx_ready_ce", 1'b0, rx_rdy);
    chk("valid_ce", 1'b1, o_valid);
    @(posedge clk);
    #1 ce = 1'b1;
    @(posedge clk);
    #1 rdy = 1'b0;
    @(negedge clk);
    chk("valid_single", 1'b0, o_valid);
    xfer(f, 388, 0, 1'b1, rows[0]);
    wait_valid();
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk("valid_rerst", 1'b0, o_valid);
    chk("rx_ready_rerst", 1'b1, rx_rdy);
    finish_test();
  end
endmodule : tb
